/* File: hdl/hbs_regs.svh */
// Constants for the half-bridge output sequencer
// Summary of operation
// [R1] Every output cycles once per two periods
// [R2] Primary drives alternate, one period each
// [R3] External sync runs ten percent above free rate
// [R4] Slower sync pulses are ignored
// [R5] Sync pulse width kept 15 to 150 ns
// [R6] Sync rising edge restarts the oscillator period
// [R7] Primary pulse limited to period minus lead
// [R8] No error current gives maximum duty
// [R9] Rectifier drives complement their primary drive
// [R10] Both rectifiers on while primaries idle
// [R11] Opposing rectifier drops one lead deadtime early
// [R12] Lead and trail deadtimes are programmable
// [R13] Rectifiers off on line undervoltage or hiccup
// [R14] Soft-start held low forces both rectifiers on
// [R15] Over-temperature disables outputs and bias regulators
// [R16] Thermal shutdown discharges soft-start, then full restart
// [R17] Bias regulator needs supply and line enable
// [R18] Reference enabled only after bias in regulation
// [R19] Outputs wait for bias, reference and line
// [R20] Volt-second clamp ends the pulse early
// [R21] Pulse starts after lead, ends on first terminate
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH

`define HBS_CLK_PERIOD_NS 100
`define HBS_OSC_PERIOD_NS 2500
`define HBS_OSC_CYCLES    (`HBS_OSC_PERIOD_NS / `HBS_CLK_PERIOD_NS)
`define HBS_SYNC_MIN_NS   15
`define HBS_SYNC_MAX_NS   150
`define HBS_CNT_W         8
`define HBS_DT_W          6
`define HBS_PHASE_RST     1'h0
`define HBS_DRIVE_RST     1'h0

`endif

/* File: hdl/hbs_pkg.sv */
// Types shared by the half-bridge output sequencer modules
`include "hbs_regs.svh"
package hbs_pkg;

	typedef enum logic [4:0] {
		HBS_ST_OFF  = 5'h01,
		HBS_ST_BIAS = 5'h02,
		HBS_ST_REF  = 5'h04,
		HBS_ST_RUN  = 5'h08,
		HBS_ST_HOT  = 5'h10
	} hbs_state_t;

	typedef struct packed {
		logic [`HBS_CNT_W-1:0] cnt;
		logic [`HBS_CNT_W-1:0] since;
		logic                  sync_prev;
		logic                  armed;
		logic                  start;
	} hbs_osc_st_t;

	typedef struct packed {
		hbs_state_t state;
		logic       bias_en;
		logic       ref_en;
		logic       out_en;
		logic       ss_dis;
	} hbs_boot_st_t;

	typedef struct packed {
		logic                 phase;
		logic                 done;
		logic [`HBS_DT_W-1:0] trail_cnt;
		logic                 hsd;
		logic                 lsd;
		logic                 sra;
		logic                 srb;
	} hbs_seq_st_t;

	function automatic logic [`HBS_DT_W-1:0] hbs_at_least_one(input logic [`HBS_DT_W-1:0] v);
		hbs_at_least_one = (v == '0) ? `HBS_DT_W'(1) : v;
	endfunction : hbs_at_least_one

endpackage : hbs_pkg

/* File: hdl/hbs_osc.sv */
// Oscillator period counter with external sync acceptance
`timescale 1ns/1ns
`include "hbs_regs.svh"
module hbs_osc #(
	parameter int PERIOD = `HBS_OSC_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic                  sync_in,
	output logic [`HBS_CNT_W-1:0]      cnt,
	output logic                       period_start
);
	import hbs_pkg::*;

	hbs_osc_st_t st_reg;
	hbs_osc_st_t st_next;
	logic        edge_seen;
	logic        accept;

	always_comb begin
		st_next = st_reg;
		st_next.sync_prev = sync_in;
		edge_seen = sync_in && !st_reg.sync_prev;
		// Only a sync interval no longer than the free-running period is honoured
		accept = edge_seen && st_reg.armed && (st_reg.since < `HBS_CNT_W'(PERIOD)); // [R4]
		if (edge_seen) begin
			st_next.since = '0;
			st_next.armed = 1'h1;
		end else if (st_reg.since < `HBS_CNT_W'(PERIOD)) begin
			st_next.since = `HBS_CNT_W'(st_reg.since + 1'h1);
		end
		if (accept || st_reg.cnt == `HBS_CNT_W'(PERIOD - 1)) begin // [R6]
			st_next.cnt = '0;
			st_next.start = 1'h1;
		end else begin
			st_next.cnt = `HBS_CNT_W'(st_reg.cnt + 1'h1);
			st_next.start = 1'h0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cnt = st_reg.cnt;
	assign period_start = st_reg.start;

	AST_SYNC_RESTART: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
		accept |=> (period_start && cnt == '0))
		else $error("accepted sync edge did not restart the period");

	AST_SLOW_SYNC_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
		(edge_seen && st_reg.since >= `HBS_CNT_W'(PERIOD) && st_reg.cnt != `HBS_CNT_W'(PERIOD - 1))
		|=> !period_start)
		else $error("slow sync edge restarted the period");

	AST_FREE_RUN: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
		(st_reg.cnt == `HBS_CNT_W'(PERIOD - 1)) |=> (period_start && cnt == '0))
		else $error("free-running period did not wrap");

endmodule : hbs_osc

/* File: hdl/hbs_startup.sv */
// Bias, reference and output enable start-up sequencing
`timescale 1ns/1ns
module hbs_startup (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic supply_present,
	input  wire logic line_undervoltage_sense_low_ok,
	input  wire logic line_undervoltage_sense_high_ok,
	input  wire logic bias_in_regulation,
	input  wire logic ref_in_regulation,
	input  wire logic over_temp,
	output logic      bias_reg_enable,
	output logic      reference_output,
	output logic      outputs_enable,
	output logic      soft_start_discharge
);
	import hbs_pkg::*;

	hbs_boot_st_t st_reg;
	hbs_boot_st_t st_next;
	logic         powered;

	always_comb begin
		st_next = st_reg;
		powered = supply_present && line_undervoltage_sense_low_ok;
		if (over_temp) begin
			st_next.state = HBS_ST_HOT; // [R15]
		end else begin
			unique case (st_reg.state)
				HBS_ST_OFF: begin
					if (powered) st_next.state = HBS_ST_BIAS; // [R17]
				end
				HBS_ST_BIAS: begin
					if (!powered) st_next.state = HBS_ST_OFF;
					else if (bias_in_regulation) st_next.state = HBS_ST_REF; // [R18]
				end
				HBS_ST_REF: begin
					if (!powered) st_next.state = HBS_ST_OFF;
					else if (!bias_in_regulation) st_next.state = HBS_ST_BIAS;
					else if (ref_in_regulation && line_undervoltage_sense_high_ok) st_next.state = HBS_ST_RUN; // [R19]
				end
				HBS_ST_RUN: begin
					if (!powered) st_next.state = HBS_ST_OFF;
					else if (!bias_in_regulation || !ref_in_regulation) st_next.state = HBS_ST_BIAS;
					else if (!line_undervoltage_sense_high_ok) st_next.state = HBS_ST_REF;
				end
				HBS_ST_HOT: begin
					st_next.state = HBS_ST_OFF; // [R16]
				end
				default: begin
					st_next.state = HBS_ST_OFF;
				end
			endcase
		end
		st_next.bias_en = (st_next.state == HBS_ST_BIAS) || (st_next.state == HBS_ST_REF)
			|| (st_next.state == HBS_ST_RUN); // [R17]
		st_next.ref_en = (st_next.state == HBS_ST_REF) || (st_next.state == HBS_ST_RUN); // [R18]
		st_next.out_en = (st_next.state == HBS_ST_RUN); // [R19]
		st_next.ss_dis = (st_next.state != HBS_ST_RUN); // [R16]
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{state: HBS_ST_OFF, bias_en: 1'h0, ref_en: 1'h0, out_en: 1'h0, ss_dis: 1'h1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign bias_reg_enable = st_reg.bias_en;
	assign reference_output = st_reg.ref_en;
	assign outputs_enable = st_reg.out_en;
	assign soft_start_discharge = st_reg.ss_dis;

	AST_HOT_STANDBY: assert property (@(posedge core_clk) disable iff (!resetn) // [R15]
		over_temp |=> (!bias_reg_enable && !reference_output && !outputs_enable && soft_start_discharge))
		else $error("over-temperature did not force standby");

	AST_HOT_RESTART: assert property (@(posedge core_clk) disable iff (!resetn) // [R16]
		($fell(over_temp) && st_reg.state == HBS_ST_HOT) |=> (st_reg.state == HBS_ST_OFF) ##1 !outputs_enable)
		else $error("thermal recovery skipped the start-up sequence");

	AST_BIAS_GATE: assert property (@(posedge core_clk) disable iff (!resetn) // [R17]
		bias_reg_enable |-> $past(supply_present && line_undervoltage_sense_low_ok))
		else $error("bias regulator enabled without supply or line");

	AST_REF_AFTER_BIAS: assert property (@(posedge core_clk) disable iff (!resetn) // [R18]
		$rose(reference_output) |-> ($past(bias_in_regulation) && bias_reg_enable))
		else $error("reference enabled before bias regulation");

	AST_OUT_GATE: assert property (@(posedge core_clk) disable iff (!resetn) // [R19]
		outputs_enable |-> $past(bias_in_regulation && ref_in_regulation && line_undervoltage_sense_high_ok))
		else $error("outputs enabled before bias, reference and line ready");

endmodule : hbs_startup

/* File: hdl/hbs_sequencer.sv */
// Half-bridge primary and rectifier drive sequencer top
`timescale 1ns/1ns
`include "hbs_regs.svh"
module hbs_sequencer #(
	parameter int PERIOD = `HBS_OSC_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 resetn,
	input  wire logic                 freq_set_sync_pin,
	input  wire logic [`HBS_DT_W-1:0] lead_deadtime,
	input  wire logic [`HBS_DT_W-1:0] trail_deadtime,
	input  wire logic                 error_terminate,
	input  wire logic                 error_current_present,
	input  wire logic                 clamp_terminate,
	input  wire logic                 supply_present,
	input  wire logic                 line_undervoltage_sense_low_ok,
	input  wire logic                 line_undervoltage_sense_high_ok,
	input  wire logic                 bias_in_regulation,
	input  wire logic                 ref_in_regulation,
	input  wire logic                 hiccup_active,
	input  wire logic                 soft_start_low,
	input  wire logic                 over_temp,
	output logic                      high_side_drive,
	output logic                      low_side_drive,
	output logic                      rectifier_drive_a,
	output logic                      rectifier_drive_b,
	output logic                      bias_reg_enable,
	output logic                      reference_output,
	output logic                      soft_start_discharge
);
	import hbs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Oscillator and start-up sequencing

	logic [`HBS_CNT_W-1:0] cnt;
	logic                  period_start;
	logic                  outputs_enable;

	hbs_osc #(
		.PERIOD (PERIOD)
	) u_osc (
		.core_clk     (core_clk),
		.resetn       (resetn),
		.sync_in      (freq_set_sync_pin),
		.cnt          (cnt),
		.period_start (period_start)
	);

	hbs_startup u_startup (
		.core_clk                        (core_clk),
		.resetn                          (resetn),
		.supply_present                  (supply_present),
		.line_undervoltage_sense_low_ok  (line_undervoltage_sense_low_ok),
		.line_undervoltage_sense_high_ok (line_undervoltage_sense_high_ok),
		.bias_in_regulation              (bias_in_regulation),
		.ref_in_regulation               (ref_in_regulation),
		.over_temp                       (over_temp),
		.bias_reg_enable                 (bias_reg_enable),
		.reference_output                (reference_output),
		.outputs_enable                  (outputs_enable),
		.soft_start_discharge            (soft_start_discharge)
	);

	////////////////////////////////////////////////////////////////////////
	// Drive sequencing

	hbs_seq_st_t          st_reg;
	hbs_seq_st_t          st_next;
	logic [`HBS_DT_W-1:0] lead_eff;
	logic                 normal;
	logic                 term_any;
	logic                 past_lead;
	logic                 pulse;
	logic                 side;
	logic                 release_opp;

	always_comb begin
		st_next = st_reg;
		lead_eff = hbs_at_least_one(lead_deadtime); // [R12]
		normal = outputs_enable && line_undervoltage_sense_high_ok && !hiccup_active;
		// Open error input means no error terminate: full duty
		term_any = clamp_terminate // [R20]
			|| (error_current_present && error_terminate) // [R8]
			|| (cnt == `HBS_CNT_W'(PERIOD - 1)); // [R7]
		past_lead = (cnt >= `HBS_CNT_W'(lead_eff)); // [R21]
		if (period_start) begin
			st_next.phase = !st_reg.phase; // [R2]
			st_next.done = 1'h0;
			st_next.trail_cnt = '0;
		end else begin
			if (past_lead && !st_reg.done && term_any) begin
				st_next.done = 1'h1; // [R21]
			end
			if (st_reg.done && st_reg.trail_cnt < trail_deadtime) begin
				st_next.trail_cnt = `HBS_DT_W'(st_reg.trail_cnt + 1'h1); // [R12]
			end
		end
		pulse = normal && !soft_start_low && !period_start && past_lead && !st_reg.done && !term_any; // [R21]
		side = st_next.phase;
		st_next.hsd = pulse && side; // [R1]
		st_next.lsd = pulse && !side; // [R2]
		// Opposing rectifier off from period start until trail expires
		release_opp = !st_next.done || (st_next.trail_cnt < trail_deadtime); // [R11]
		if (!normal) begin
			st_next.sra = 1'h0; // [R13]
			st_next.srb = 1'h0;
		end else if (soft_start_low) begin
			st_next.sra = 1'h1; // [R14]
			st_next.srb = 1'h1;
		end else begin
			st_next.sra = !(side && release_opp); // [R9]
			st_next.srb = !(!side && release_opp); // [R10]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{phase: `HBS_PHASE_RST, done: 1'h0, trail_cnt: '0, hsd: `HBS_DRIVE_RST,
				lsd: `HBS_DRIVE_RST, sra: `HBS_DRIVE_RST, srb: `HBS_DRIVE_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign high_side_drive = st_reg.hsd;
	assign low_side_drive = st_reg.lsd;
	assign rectifier_drive_a = st_reg.sra;
	assign rectifier_drive_b = st_reg.srb;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Primary on-time within the current period
	logic [`HBS_CNT_W-1:0] on_len;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			on_len <= '0;
		end else if (period_start) begin
			on_len <= '0;
		end else if (st_next.hsd || st_next.lsd) begin
			on_len <= `HBS_CNT_W'(on_len + 1'h1);
		end
	end

	AST_NO_OVERLAP: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
		!(high_side_drive && low_side_drive))
		else $error("both primary drives active together");

	AST_PHASE_TOGGLE: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
		period_start |=> (st_reg.phase != $past(st_reg.phase)))
		else $error("phase did not alternate at period start");

	AST_HS_PHASE: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
		high_side_drive |-> (st_reg.phase && !low_side_drive))
		else $error("high side drive outside its period");

	AST_DUTY_LIMIT: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
		on_len <= `HBS_CNT_W'(PERIOD) - `HBS_CNT_W'(lead_eff))
		else $error("primary pulse exceeded period minus lead deadtime");

	AST_LEAD_GAP: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
		$rose(high_side_drive) |-> (!rectifier_drive_a && $past(!rectifier_drive_a)))
		else $error("rectifier a not released before high side pulse");

	AST_LEAD_GAP_LO: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
		$rose(low_side_drive) |-> (!rectifier_drive_b && $past(!rectifier_drive_b)))
		else $error("rectifier b not released before low side pulse");

	AST_COMPLEMENT: assert property (@(posedge core_clk) disable iff (!resetn) // [R9]
		(high_side_drive |-> !rectifier_drive_a) and (low_side_drive |-> !rectifier_drive_b))
		else $error("rectifier drive on with its primary");

	AST_SHARE_IDLE: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
		($fell(high_side_drive) && normal && !soft_start_low) |-> rectifier_drive_b)
		else $error("rectifier b dropped as high side pulse ended");

	AST_TRAIL: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
		($fell(high_side_drive) && trail_deadtime >= `HBS_DT_W'(2) && !period_start && !$past(soft_start_low))
		|-> !rectifier_drive_a)
		else $error("rectifier a reasserted before trail deadtime");

	AST_LINE_HICCUP: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
		(!line_undervoltage_sense_high_ok || hiccup_active) |=> (!rectifier_drive_a && !rectifier_drive_b))
		else $error("rectifiers active during undervoltage or hiccup");

	AST_SS_LOW: assert property (@(posedge core_clk) disable iff (!resetn) // [R14]
		(normal && soft_start_low) |=> (rectifier_drive_a && rectifier_drive_b && !high_side_drive && !low_side_drive))
		else $error("soft-start low did not hold both rectifiers on");

	AST_CLAMP_END: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
		(clamp_terminate && !period_start) |=> (!high_side_drive && !low_side_drive))
		else $error("clamp terminate did not end the pulse");

	AST_ERR_END: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
		(error_current_present && error_terminate && !period_start) |=> (!high_side_drive && !low_side_drive))
		else $error("error terminate did not end the pulse");

	AST_MAX_DUTY: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
		(normal && !soft_start_low && !error_current_present && !clamp_terminate && !period_start
		&& !st_reg.done && cnt == `HBS_CNT_W'(lead_eff)) |=> (high_side_drive || low_side_drive))
		else $error("open error input did not give full duty");

	AST_STANDBY_OFF: assert property (@(posedge core_clk) disable iff (!resetn) // [R15]
		over_temp |=> ##1 (!high_side_drive && !low_side_drive && !rectifier_drive_a && !rectifier_drive_b))
		else $error("switching outputs active in thermal standby");

endmodule : hbs_sequencer

/* File: dv/hbs_far_side.sv */
// Far-side model: gate loads with comparator trips and a sync source
`timescale 1ns/1ns
module hbs_far_side (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       high_side_drive,
	input  wire logic       low_side_drive,
	input  wire logic [7:0] err_m,
	input  wire logic [7:0] clamp_m,
	input  wire logic [7:0] sync_gap,
	output logic            error_terminate,
	output logic            clamp_terminate,
	output logic            freq_set_sync_pin
);
	logic [7:0] on_cnt;
	logic [7:0] sync_cnt;
	logic       prim;
	logic       fire;
	logic       sync_q = 1'b0;
	assign prim = high_side_drive | low_side_drive;
	assign freq_set_sync_pin = sync_q;
	// Comparators trip a fixed count into each pulse
	assign error_terminate = prim && on_cnt >= err_m;
	assign clamp_terminate = prim && on_cnt >= clamp_m;
	assign fire = sync_gap != 8'h00 && sync_cnt >= sync_gap - 8'h01;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			on_cnt   <= 8'h00;
			sync_cnt <= 8'h00;
		end else begin
			on_cnt   <= prim ? on_cnt + 8'h01 : 8'h00;
			sync_cnt <= fire ? 8'h00 : sync_cnt + 8'h01;
		end
	end
	// Sync pulse 140 ns wide, one every sync_gap cycles
	always @(posedge core_clk) begin
		if (fire) begin
			#20 sync_q = 1'b1;
			#140 sync_q = 1'b0;
		end
	end
endmodule : hbs_far_side

/* File: dv/hbs_sequencer_test.sv */
// Self-checking bench for the half-bridge output sequencer
`timescale 1ns/1ns
`include "hbs_regs.svh"
module hbs_sequencer_test;
	typedef struct {
		logic [5:0] lead;
		logic [5:0] trail;
		logic       ecp;
		logic [7:0] em;
		logic [7:0] cm;
		logic [7:0] on;
		logic [7:0] gl;
		logic       tc;
	} hbs_row_t;
	localparam int PER = 10;
	hbs_row_t rows [5] = '{
		'{6'h03, 6'h02, 1'b1, 8'h01, 8'h09, 8'h02, 8'h03, 1'b1},
		'{6'h03, 6'h02, 1'b0, 8'h01, 8'h09, 8'h06, 8'h03, 1'b0},
		'{6'h02, 6'h01, 1'b1, 8'h09, 8'h02, 8'h03, 8'h02, 1'b1},
		'{6'h00, 6'h03, 1'b1, 8'h02, 8'h09, 8'h03, 8'h01, 1'b1},
		'{6'h01, 6'h01, 1'b0, 8'h01, 8'h09, 8'h08, 8'h01, 1'b0}};
	logic                 core_clk = 1'b0;
	logic                 resetn   = 1'b0;
	logic [`HBS_DT_W-1:0] lead     = 6'h03;
	logic [`HBS_DT_W-1:0] trail    = 6'h02;
	logic                 ecp      = 1'b1;
	logic                 supply   = 1'b0;
	logic                 low_ok   = 1'b0;
	logic                 high_ok  = 1'b0;
	logic                 bias_ok  = 1'b0;
	logic                 ref_ok   = 1'b0;
	logic                 hiccup   = 1'b0;
	logic                 ss_low   = 1'b0;
	logic                 hot      = 1'b0;
	logic [7:0]           err_m    = 8'h09;
	logic [7:0]           clamp_m  = 8'h09;
	logic [7:0]           sync_gap = 8'h00;
	wire logic            sync_pin;
	wire logic            err_t;
	wire logic            clamp_t;
	logic                 hsd, lsd, sra, srb, bias_en, ref_out, ssd;
	logic [7:0]           cyc = 8'h00, t_hr = 8'h00, t_sr = 8'h00, t_hf = 8'h00, t_saf = 8'h00;
	logic [7:0]           per_h = 8'h00, per_s = 8'h00, on_h = 8'h00, gap_l = 8'h00, gap_t = 8'h00;
	logic [7:0]           ovl = 8'h00, both = 8'h00;
	logic                 h_q = 1'b0, sa_q = 1'b0;
	logic                 clr = 1'b0;
	int                   bad_count = 0;
	int                   checked = 0;

	always #50 core_clk = ~core_clk;

	hbs_sequencer #(.PERIOD(PER)) uut (.core_clk(core_clk), .resetn(resetn), .freq_set_sync_pin(sync_pin),
		.lead_deadtime(lead), .trail_deadtime(trail), .error_terminate(err_t), .error_current_present(ecp),
		.clamp_terminate(clamp_t), .supply_present(supply), .line_undervoltage_sense_low_ok(low_ok),
		.line_undervoltage_sense_high_ok(high_ok), .bias_in_regulation(bias_ok), .ref_in_regulation(ref_ok),
		.hiccup_active(hiccup), .soft_start_low(ss_low), .over_temp(hot), .high_side_drive(hsd),
		.low_side_drive(lsd), .rectifier_drive_a(sra), .rectifier_drive_b(srb), .bias_reg_enable(bias_en),
		.reference_output(ref_out), .soft_start_discharge(ssd));
	hbs_far_side far (.core_clk(core_clk), .resetn(resetn), .high_side_drive(hsd), .low_side_drive(lsd),
		.err_m(err_m), .clamp_m(clamp_m), .sync_gap(sync_gap), .error_terminate(err_t),
		.clamp_terminate(clamp_t), .freq_set_sync_pin(sync_pin));

	////////////////////////////////////////////////////////////////
	// Edge timing monitor, sampled mid-cycle
	always @(negedge core_clk) begin
		cyc  <= cyc + 8'h01;
		h_q  <= hsd;
		sa_q <= sra;
		if (hsd && !h_q) begin
			per_h <= cyc - t_hr;
			t_hr  <= cyc;
			gap_l <= cyc - t_saf;
		end
		if (!hsd && h_q) begin
			on_h <= cyc - t_hr;
			t_hf <= cyc;
		end
		if (sra && !sa_q) begin
			per_s <= cyc - t_sr;
			t_sr  <= cyc;
			gap_t <= cyc - t_hf;
		end
		if (!sra && sa_q)
			t_saf <= cyc;
		if ((hsd && lsd) || (hsd && sra) || (lsd && srb))
			ovl <= ovl + 8'h01;
		if (sra && srb)
			both <= both + 8'h01;
		// Clear of ovl, both, per_h and on_h wins over their updates in the same cycle
		if (clr) begin
			ovl   <= 8'h00;
			both  <= 8'h00;
			per_h <= 8'h00;
			on_h  <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step

	task automatic look(input int n);
		step(n);
		@(negedge core_clk);
	endtask : look

	function automatic logic [7:0] drv();
		return {4'h0, hsd, lsd, sra, srb};
	endfunction : drv

	function automatic logic [7:0] boot();
		return {5'h00, bias_en, ref_out, ssd};
	endfunction : boot

	task automatic measure();
		step(30);
		clr <= 1'b1;
		step(1);
		clr <= 1'b0;
		look(60);
	endtask : measure

	task automatic apply(input hbs_row_t r);
		// Retime early in a high period, while the on-time count is low
		@(negedge sra);
		@(posedge core_clk);
		lead    <= r.lead;
		trail   <= r.trail;
		ecp     <= r.ecp;
		err_m   <= r.em;
		clamp_m <= r.cm;
	endtask : apply

	task automatic bring_up();
		@(posedge core_clk);
		supply <= 1'b1;
		low_ok <= 1'b1;
		look(3);
		check("bias_reg_enable", {7'h00, bias_en}, 8'h01);
		check("reference_early", {7'h00, ref_out}, 8'h00);
		@(posedge core_clk);
		bias_ok <= 1'b1;
		look(3);
		check("reference_output", {7'h00, ref_out}, 8'h01);
		@(posedge core_clk);
		ref_ok <= 1'b1;
		look(30);
		check("drives_before_line", drv(), 8'h00);
		@(posedge core_clk);
		high_ok <= 1'b1;
	endtask : bring_up

	////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		bad_count++;
		give_verdict();
	end

	initial begin
		look(5);
		check("reset_drives", drv(), 8'h00);
		check("reset_boot", boot(), 8'h01);
		@(posedge core_clk);
		resetn <= 1'b1;
		bring_up();
		foreach (rows[i]) begin
			apply(rows[i]);
			measure();
			check("on_time", on_h, rows[i].on);
			check("lead_gap", gap_l, rows[i].gl);
			check("high_period", per_h, 8'h14);
			check("rect_period", per_s, 8'h14);
			check("overlap", ovl, 8'h00);
			if (rows[i].tc) begin
				check("trail_gap", gap_t, {2'b00, rows[i].trail});
				check("both_rect", {7'h00, both != 8'h00}, 8'h01);
			end
		end
		apply(rows[0]);
		sync_gap <= 8'h09;
		measure();
		check("sync_period", per_h, 8'h12);
		@(posedge core_clk);
		sync_gap <= 8'h0D;
		measure();
		check("slow_sync", per_h, 8'h14);
		@(posedge core_clk);
		sync_gap <= 8'h00;
		ss_low   <= 1'b1;
		look(25);
		check("soft_start_low", drv(), 8'h03);
		@(posedge core_clk);
		ss_low <= 1'b0;
		hiccup <= 1'b1;
		look(5);
		check("hiccup", drv(), 8'h00);
		@(posedge core_clk);
		hiccup  <= 1'b0;
		high_ok <= 1'b0;
		look(5);
		check("line_low", drv(), 8'h00);
		@(posedge core_clk);
		high_ok <= 1'b1;
		hot     <= 1'b1;
		look(3);
		check("hot_drives", drv(), 8'h00);
		check("hot_boot", boot(), 8'h01);
		@(posedge core_clk);
		hot <= 1'b0;
		look(10);
		check("restart_boot", boot(), 8'h06);
		measure();
		check("restart_period", per_h, 8'h14);
		@(posedge core_clk);
		supply <= 1'b0;
		look(2);
		check("supply_loss", {7'h00, bias_en}, 8'h00);
		check("supply_drives", drv(), 8'h00);
		@(posedge core_clk);
		resetn  <= 1'b0;
		low_ok  <= 1'b0;
		high_ok <= 1'b0;
		bias_ok <= 1'b0;
		ref_ok  <= 1'b0;
		look(2);
		check("rerst_drives", drv(), 8'h00);
		check("rerst_boot", boot(), 8'h01);
		@(posedge core_clk);
		resetn <= 1'b1;
		bring_up();
		measure();
		check("rerst_on_time", on_h, rows[0].on);
		give_verdict();
	end
endmodule : hbs_sequencer_test
